// ### src/arci_consts.vh
// Constants for the analog remote control interface
`ifndef ARCI_CONSTS_VH
`define ARCI_CONSTS_VH

// Register offsets (byte addresses)
`define ARCI_ADDR_CTRL 4'h0
`define ARCI_ADDR_ROUTE 4'h4
`define ARCI_ADDR_STATUS 4'h8
`define ARCI_ADDR_ALMCNT 4'hc

// Control register fields
`define ARCI_CTRL_RANGE10 0
`define ARCI_CTRL_SBINV 1
`define ARCI_CTRL_ALLOW 2
`define ARCI_CTRL_RESET 16'h0005
`define ARCI_ROUTE_RESET 16'h001c

// Status register fields
`define ARCI_STAT_ANALOG 0
`define ARCI_STAT_DIGITAL 1
`define ARCI_STAT_DCON 2
`define ARCI_STAT_PEND_LO 8

// Alarm bit positions
`define ARCI_ALM_OT 0
`define ARCI_ALM_PF 1
`define ARCI_ALM_OVP 2
`define ARCI_ALM_OCP 3
`define ARCI_ALM_OPP 4
`define ARCI_ALM_N 5

// Converter full scale codes
`define ARCI_FS_10V 16'd26214
`define ARCI_FS_5V 16'd13107

// Timing
`define ARCI_CLK_HZ 50000000
`define ARCI_SAMPLE_HZ 500
`define ARCI_ACK_MIN_MS 50

`endif

// ### src/arci_sampler.v
// Set-value input sampler with range scaling and overrange clipping
`timescale 1ns/1ps
`include "arci_consts.vh"
module arci_sampler (
    // Clock, reset, enable
    input wire clk_sys,
    input wire nrst,
    input wire ce,
    // Sampling control
    input wire tick,
    input wire range10,
    // Converter code and result
    input wire [15:0] code,
    output reg [15:0] value_r,
    output reg clipped_r
);
    reg [15:0] value_nxt;
    reg clipped_nxt;

    // Clip to full scale of the range, then stretch the 5 V range to full steps
    always @* begin
        value_nxt = value_r;
        clipped_nxt = clipped_r;
        if (tick) begin
            if (range10) begin
                clipped_nxt = (code > `ARCI_FS_10V);
                value_nxt = clipped_nxt ? `ARCI_FS_10V : code;
            end else begin
                clipped_nxt = (code > `ARCI_FS_5V);
                value_nxt = clipped_nxt ? `ARCI_FS_10V : {code[14:0], 1'b0};
            end
        end
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            value_r <= 16'h0000;
            clipped_r <= 1'b0;
        end else if (ce) begin
            value_r <= value_nxt;
            clipped_r <= clipped_nxt;
        end
    end
endmodule

// ### src/arci_top.v
// Control logic of the isolated analog remote control interface
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "arci_consts.vh"
module arci_top #(
    parameter SAMPLE_CYCLES = `ARCI_CLK_HZ / `ARCI_SAMPLE_HZ,
    parameter ACK_SAMPLES = (`ARCI_ACK_MIN_MS * `ARCI_SAMPLE_HZ + 999) / 1000
) (
    // Clock, reset, enable
    input wire clk_sys,
    input wire nrst,
    input wire ce,
    // Register port
    input wire [3:0] regAddr,
    input wire [15:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [15:0] regRdata_r,
    // Interface pins, asynchronous
    input wire remoteSelectPin,
    input wire outputStandbyInput,
    input wire resistanceModePin,
    // Converter codes of set-value inputs
    input wire [15:0] voltageSetpointInput,
    input wire [15:0] currentSetpointInput,
    input wire [15:0] powerSetpointInput,
    input wire [15:0] resistanceSetpointInput,
    // Front panel values
    input wire [15:0] panelVoltage,
    input wire [15:0] panelCurrent,
    input wire [15:0] panelPower,
    input wire [15:0] panelResistance,
    input wire [15:0] panelOvpThreshold,
    input wire panelOutputOn,
    // Digital interface ownership
    input wire digitalRequest,
    input wire digitalRelease,
    input wire [1:0] digitalSource,
    // Actual values, 26214 equals 100 percent
    input wire [15:0] voltageActual,
    input wire [15:0] currentActual,
    // Alarm events
    input wire [4:0] alarmEvent,
    // Set values in use and displayed
    output reg [15:0] voltageSetValue_r,
    output reg [15:0] currentSetValue_r,
    output reg [15:0] powerSetValue_r,
    output reg [15:0] resistanceSetValue_r,
    output reg resistanceModeOn_r,
    output reg [15:0] ovpThreshold_r,
    // Analog outputs, converter codes
    output reg [15:0] referenceOutput_r,
    output reg [15:0] voltageActualOutput_r,
    output reg [15:0] currentActualOutput_r,
    // Digital outputs
    output reg alarm1Output_r,
    output reg alarm2Output_r,
    output reg dcOutputOn_r,
    // Control ownership
    output reg analogActive_r,
    output reg [2:0] controlOwner_r,
    output reg digitalError_r
);
    // Registers
    reg [15:0] ctrl_r;
    reg [15:0] route_r;
    reg [15:0] alarmCount_r;
    reg [4:0] pending_r;
    reg [4:0] pending_nxt;
    // Sampling
    reg [16:0] tickCnt_r;
    reg tick_r;
    reg [2:0] remSync1_r, sbSync1_r, resSync1_r;
    reg remSync2_r, sbSync2_r, resSync2_r;
    reg remSmp_r, remSmpPrev_r, sbSmp_r, resSmp_r;
    // Ownership and acknowledge
    reg analogReq_r;
    reg digitalOwner_r;
    reg [1:0] digitalSrc_r;
    reg [7:0] lowCnt_r;
    reg sbOnPrev_r;
    reg ackPulse_r;
    wire range10 = ctrl_r[`ARCI_CTRL_RANGE10];
    wire sbInvert = ctrl_r[`ARCI_CTRL_SBINV];
    wire allowRemote = ctrl_r[`ARCI_CTRL_ALLOW];
    wire sbOn = sbSmp_r ^ sbInvert;
    wire analogNow = analogReq_r & allowRemote & ~digitalOwner_r;
    wire [15:0] vSmp, cSmp, pSmp, rSmp;
    wire [3:0] clipped;

    // Monitor scaling: 100 percent maps to the range full scale
    function [15:0] monScale;
        input [15:0] actual;
        input rng10;
        reg [15:0] lim;
        begin
            lim = (actual > `ARCI_FS_10V) ? `ARCI_FS_10V : actual;
            monScale = rng10 ? lim : {1'b0, lim[15:1]};
        end
    endfunction

    // Sample tick no faster than the sample rate
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tickCnt_r <= 17'h00000;
            tick_r <= 1'b0;
        end else if (ce) begin
            tick_r <= (tickCnt_r == SAMPLE_CYCLES[16:0] - 17'h00001);
            if (tickCnt_r == SAMPLE_CYCLES[16:0] - 17'h00001) begin
                tickCnt_r <= 17'h00000;
            end else begin
                tickCnt_r <= tickCnt_r + 17'h00001;
            end
        end
    end

    // Pin synchronisers and sampled pin states
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            remSync1_r <= 3'h7;
            sbSync1_r <= 3'h7;
            resSync1_r <= 3'h7;
            remSync2_r <= 1'b1;
            sbSync2_r <= 1'b1;
            resSync2_r <= 1'b1;
            remSmp_r <= 1'b1;
            remSmpPrev_r <= 1'b1;
            sbSmp_r <= 1'b1;
            resSmp_r <= 1'b1;
        end else if (ce) begin
            remSync1_r <= {2'b11, remoteSelectPin};
            sbSync1_r <= {2'b11, outputStandbyInput};
            resSync1_r <= {2'b11, resistanceModePin};
            remSync2_r <= remSync1_r[0];
            sbSync2_r <= sbSync1_r[0];
            resSync2_r <= resSync1_r[0];
            if (tick_r) begin
                remSmp_r <= remSync2_r;
                remSmpPrev_r <= remSmp_r;
                sbSmp_r <= sbSync2_r;
                resSmp_r <= resSync2_r;
            end
        end
    end

    // Set-value samplers
    arci_sampler uSmpV (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .tick(tick_r), .range10(range10),
        .code(voltageSetpointInput), .value_r(vSmp), .clipped_r(clipped[0]));
    arci_sampler uSmpC (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .tick(tick_r), .range10(range10),
        .code(currentSetpointInput), .value_r(cSmp), .clipped_r(clipped[1]));
    arci_sampler uSmpP (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .tick(tick_r), .range10(range10),
        .code(powerSetpointInput), .value_r(pSmp), .clipped_r(clipped[2]));
    arci_sampler uSmpR (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .tick(tick_r), .range10(range10),
        .code(resistanceSetpointInput), .value_r(rSmp), .clipped_r(clipped[3]));

    // Control ownership between analog port and digital interfaces
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            analogReq_r <= 1'b0;
            digitalOwner_r <= 1'b0;
            digitalSrc_r <= 2'b00;
            digitalError_r <= 1'b0;
        end else if (ce) begin
            digitalError_r <= 1'b0;
            if (remSmp_r) begin
                analogReq_r <= 1'b0;
            end else if (remSmpPrev_r && !digitalOwner_r) begin
                analogReq_r <= 1'b1;
            end
            if (!allowRemote) begin
                digitalOwner_r <= 1'b0;
            end else if (digitalRequest && analogNow) begin
                digitalError_r <= 1'b1;
            end else if (digitalRequest && !digitalOwner_r) begin
                digitalOwner_r <= 1'b1;
                digitalSrc_r <= digitalSource;
            end else if (digitalRelease) begin
                digitalOwner_r <= 1'b0;
            end
        end
    end

    // Acknowledge: count consecutive off samples on the standby input
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            lowCnt_r <= 8'h00;
            sbOnPrev_r <= 1'b1;
            ackPulse_r <= 1'b0;
        end else if (ce) begin
            ackPulse_r <= 1'b0;
            if (tick_r) begin
                sbOnPrev_r <= sbOn;
                if (!sbOn) begin
                    if (lowCnt_r != 8'hff) begin
                        lowCnt_r <= lowCnt_r + 8'h01;
                    end
                end else begin
                    lowCnt_r <= 8'h00;
                    if (!sbOnPrev_r && analogActive_r && lowCnt_r >= ACK_SAMPLES[7:0]) begin
                        ackPulse_r <= 1'b1;
                    end
                end
            end
        end
    end

    // Pending alarms: new events win over acknowledge
    always @* begin
        pending_nxt = ackPulse_r ? 5'h00 : pending_r;
        pending_nxt = pending_nxt | alarmEvent;
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pending_r <= 5'h00;
            alarmCount_r <= 16'h0000;
        end else if (ce) begin
            pending_r <= pending_nxt;
            if ((alarmEvent & ~pending_r) != 5'h00 && alarmCount_r != 16'hffff) begin
                alarmCount_r <= alarmCount_r + 16'h0001;
            end
        end
    end

    // Register writes
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= `ARCI_CTRL_RESET;
            route_r <= `ARCI_ROUTE_RESET;
        end else if (ce && regWr) begin
            if (regAddr == `ARCI_ADDR_CTRL) begin
                ctrl_r <= {13'h0000, regWdata[2:0]};
            end
            if (regAddr == `ARCI_ADDR_ROUTE) begin
                route_r <= {11'h000, regWdata[4:0]};
            end
        end
    end

    // Register reads, data in the following cycle
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            regRdata_r <= 16'h0000;
        end else if (ce) begin
            regRdata_r <= 16'h0000;
            if (regRd) begin
                case (regAddr)
                    `ARCI_ADDR_CTRL: begin
                        regRdata_r <= ctrl_r;
                    end
                    `ARCI_ADDR_ROUTE: begin
                        regRdata_r <= route_r;
                    end
                    `ARCI_ADDR_STATUS: begin
                        regRdata_r <= {3'h0, pending_r, 4'h0, clipped[3], dcOutputOn_r,
                            digitalOwner_r, analogActive_r};
                    end
                    `ARCI_ADDR_ALMCNT: begin
                        regRdata_r <= alarmCount_r;
                    end
                    default: begin
                        regRdata_r <= 16'h0000;
                    end
                endcase
            end
        end
    end

    // Set values, analog outputs and alarm pins
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            voltageSetValue_r <= 16'h0000;
            currentSetValue_r <= 16'h0000;
            powerSetValue_r <= 16'h0000;
            resistanceSetValue_r <= 16'h0000;
            resistanceModeOn_r <= 1'b0;
            ovpThreshold_r <= 16'h0000;
            referenceOutput_r <= 16'h0000;
            voltageActualOutput_r <= 16'h0000;
            currentActualOutput_r <= 16'h0000;
            alarm1Output_r <= 1'b0;
            alarm2Output_r <= 1'b0;
            dcOutputOn_r <= 1'b0;
            analogActive_r <= 1'b0;
            controlOwner_r <= 3'h0;
        end else if (ce) begin
            analogActive_r <= analogNow;
            controlOwner_r <= analogNow ? 3'h4 : (digitalOwner_r ? {1'b0, digitalSrc_r} | 3'h1 : 3'h0);
            if (analogNow) begin
                voltageSetValue_r <= vSmp;
                currentSetValue_r <= cSmp;
                powerSetValue_r <= pSmp;
                resistanceSetValue_r <= rSmp;
                resistanceModeOn_r <= ~resSmp_r;
            end else begin
                voltageSetValue_r <= panelVoltage;
                currentSetValue_r <= panelCurrent;
                powerSetValue_r <= panelPower;
                resistanceSetValue_r <= panelResistance;
                resistanceModeOn_r <= 1'b0;
            end
            ovpThreshold_r <= panelOvpThreshold;
            referenceOutput_r <= range10 ? `ARCI_FS_10V : `ARCI_FS_5V;
            voltageActualOutput_r <= monScale(voltageActual, range10);
            currentActualOutput_r <= monScale(currentActual, range10);
            alarm1Output_r <= |(pending_nxt & ~route_r[4:0]);
            alarm2Output_r <= |(pending_nxt & route_r[4:0]);
            dcOutputOn_r <= sbOn && (pending_nxt == 5'h00) && (analogNow || panelOutputOn);
        end
    end
endmodule

// ### tb/arci_top_asserts.sv
// Port-level assertions for the analog remote control interface
`timescale 1ns/1ps
module arci_top_asserts #(
    parameter SAMPLE_CYCLES = 10,
    parameter ACK_SAMPLES = 3
) (
    // Clock and reset
    input wire clk_sys,
    input wire nrst,
    // Register writes
    input wire [3:0] regAddr,
    input wire [15:0] regWdata,
    input wire regWr,
    // Inputs watched
    input wire [15:0] panelOvpThreshold,
    input wire [15:0] voltageActual,
    input wire [4:0] alarmEvent,
    input wire digitalRequest,
    // Outputs watched
    input wire [15:0] ovpThreshold_r,
    input wire [15:0] voltageActualOutput_r,
    input wire [15:0] referenceOutput_r,
    input wire [15:0] voltageSetValue_r,
    input wire alarm1Output_r,
    input wire alarm2Output_r,
    input wire dcOutputOn_r,
    input wire digitalError_r,
    input wire analogActive_r,
    input wire [2:0] controlOwner_r
);
    logic rng_r;
    logic rngOld_r;
    logic [4:0] route_r;
    logic [15:0] prevV_r;
    int gap_r;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    function automatic logic [15:0] monExp(input logic [15:0] a, input logic r);
        logic [15:0] m;
        m = (a > 16'd26214) ? 16'd26214 : a;
        return r ? m : (m >> 1);
    endfunction
    // Shadow of range and alarm routing, and cycles since the last set value change
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rng_r <= 1'b1;
            rngOld_r <= 1'b1;
            route_r <= 5'h1c;
            prevV_r <= 16'h0;
            gap_r <= 0;
        end else begin
            if (regWr && regAddr == 4'h0) rng_r <= regWdata[0];
            if (regWr && regAddr == 4'h4) route_r <= regWdata[4:0];
            rngOld_r <= rng_r;
            prevV_r <= voltageSetValue_r;
            gap_r <= (voltageSetValue_r != prevV_r) ? 1 : ((gap_r < 9999) ? gap_r + 1 : gap_r);
        end
    end
    a_ref_scale: assert property ($past(nrst) && rng_r == rngOld_r |->
        referenceOutput_r == (rng_r ? 16'd26214 : 16'd13107)) else $error("reference level wrong");
    a_ovp_local: assert property ($past(nrst) |-> ovpThreshold_r == $past(panelOvpThreshold))
        else $error("overvoltage threshold not from panel");
    a_monitor_scale: assert property ($past(nrst) && rng_r == rngOld_r && $stable(voltageActual) |->
        voltageActualOutput_r == monExp(voltageActual, rng_r)) else $error("monitor output scaling wrong");
    a_alarm_one: assert property (|(alarmEvent & ~route_r) |-> ##[1:2] alarm1Output_r)
        else $error("first alarm output missing");
    a_alarm_two: assert property (|(alarmEvent & route_r) |-> ##[1:2] alarm2Output_r)
        else $error("second alarm output missing");
    a_alarm_dc_off: assert property (|alarmEvent |=> !dcOutputOn_r) else $error("output on after alarm");
    a_digital_refused: assert property (digitalRequest && analogActive_r |=> digitalError_r)
        else $error("digital request not refused");
    a_owner_analog: assert property (analogActive_r && $past(analogActive_r) |-> controlOwner_r == 3'h4)
        else $error("owner not analog");
    a_sample_gap: assert property (analogActive_r && $past(analogActive_r) && voltageSetValue_r != prevV_r |->
        gap_r >= SAMPLE_CYCLES) else $error("set value sampled too often");
    a_set_clip: assert property (analogActive_r |-> voltageSetValue_r <= 16'd26214)
        else $error("set value above full scale");
    c_analog_on: cover property ($rose(analogActive_r));
    c_refused: cover property (digitalError_r);
    c_both_alarms: cover property (alarm1Output_r && alarm2Output_r);
endmodule
bind arci_top arci_top_asserts #(.SAMPLE_CYCLES(SAMPLE_CYCLES), .ACK_SAMPLES(ACK_SAMPLES)) uChk (.*);

// ### tb/arci_plc_model.sv
// Behavioural model of the external analog controller
`timescale 1ns/1ps
module arci_plc_model (
    // Clock
    input wire clk_sys,
    // Bench commands
    input wire wantRemote,
    input wire ackGo,
    input wire [15:0] lowCycles,
    // Interface pins, device outputs are never read
    output wire remoteSelectPin,
    output wire outputStandbyInput
);
    logic [15:0] lowCnt = 16'h0;
    always @(posedge clk_sys) begin
        if (ackGo) lowCnt <= lowCycles;
        else if (lowCnt != 16'h0) lowCnt <= lowCnt - 16'h1;
    end
    assign remoteSelectPin = ~wantRemote;
    assign outputStandbyInput = (lowCnt == 16'h0);
endmodule

// ### tb/arci_top_test.sv
// Self-checking bench for the analog remote control interface
`timescale 1ns/1ps
module arci_top_test;
    localparam int SC = 10;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0;
    logic regWr = 1'b0, regRd = 1'b0, resistanceModePin = 1'b1, panelOutputOn = 1'b1;
    logic digitalRequest = 1'b0, digitalRelease = 1'b0, wantRemote = 1'b0, ackGo = 1'b0;
    logic [1:0] digitalSource = 2'h2;
    logic [4:0] alarmEvent = 5'h0;
    logic [15:0] voltageSetpointInput = 16'h0, currentSetpointInput = 16'h0, powerSetpointInput = 16'h0;
    logic [15:0] resistanceSetpointInput = 16'h0, voltageActual = 16'h0, currentActual = 16'h0;
    logic [15:0] panelVoltage = 16'h0100, panelCurrent = 16'h0200, panelPower = 16'h0300;
    logic [15:0] panelResistance = 16'h0400, panelOvpThreshold = 16'h5000, lowCycles = 16'h0, rd;
    wire remoteSelectPin, outputStandbyInput, resistanceModeOn_r, alarm1Output_r, alarm2Output_r;
    wire dcOutputOn_r, analogActive_r, digitalError_r;
    wire [2:0] controlOwner_r;
    wire [15:0] regRdata_r, voltageSetValue_r, currentSetValue_r, powerSetValue_r, resistanceSetValue_r;
    wire [15:0] ovpThreshold_r, referenceOutput_r, voltageActualOutput_r, currentActualOutput_r;
    int errors = 0;
    int testsRun = 0;
    int cycles = 0;
    arci_top #(.SAMPLE_CYCLES(SC), .ACK_SAMPLES(3)) DUT (.*);
    arci_plc_model uPlc (.*);
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            give_verdict();
        end
    end
    task chk16(input logic [15:0] got, input logic [15:0] exp);
        testsRun++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chkBit(input logic got, input logic exp);
        chk16({15'h0, got}, {15'h0, exp});
    endtask
    task regWrite(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    task regRead(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 d = regRdata_r;
    endtask
    task waitSamples(input int n);
        repeat (n * SC) @(posedge clk_sys);
        #1;
    endtask
    task waitActive(input logic v);
        for (int i = 0; i < 8 * SC && analogActive_r !== v; i++) @(posedge clk_sys);
        #1 chkBit(analogActive_r, v);
    endtask
    task pulse(input int which);
        @(posedge clk_sys);
        if (which == 0) digitalRequest <= 1'b1;
        else digitalRelease <= 1'b1;
        @(posedge clk_sys);
        digitalRequest <= 1'b0;
        digitalRelease <= 1'b0;
        #1;
    endtask
    task ackPulse(input logic [15:0] n, input int w);
        @(posedge clk_sys);
        lowCycles <= n;
        ackGo <= 1'b1;
        @(posedge clk_sys);
        ackGo <= 1'b0;
        waitSamples(w);
    endtask
    task testRegisters;
        regRead(4'h0, rd);
        chk16(rd, 16'h0005);
        regRead(4'h4, rd);
        chk16(rd, 16'h001c);
        regWrite(4'h2, 16'hffff);
        regRead(4'h2, rd);
        chk16(rd, 16'h0000);
        regRead(4'h8, rd);
        chk16(rd, 16'h0004);
        chk16(referenceOutput_r, 16'd26214);
        chk16(voltageSetValue_r, panelVoltage);
        $display("Test registers done");
    endtask
    task testAnalog;
        voltageSetpointInput <= 16'd1000;
        currentSetpointInput <= 16'd2000;
        powerSetpointInput <= 16'd3000;
        resistanceSetpointInput <= 16'd4000;
        resistanceModePin <= 1'b0;
        panelOvpThreshold <= 16'h6000;
        wantRemote <= 1'b1;
        waitActive(1'b1);
        waitSamples(2);
        chk16(voltageSetValue_r, 16'd1000);
        chk16(currentSetValue_r, 16'd2000);
        chk16(powerSetValue_r, 16'd3000);
        chk16(resistanceSetValue_r, 16'd4000);
        chkBit(resistanceModeOn_r, 1'b1);
        chk16(ovpThreshold_r, 16'h6000);
        chk16({13'h0, controlOwner_r}, 16'h0004);
        pulse(0);
        chkBit(digitalError_r, 1'b1);
        $display("Test analog done");
    endtask
    task testRange;
        voltageSetpointInput <= 16'd30000;
        voltageActual <= 16'd30000;
        currentActual <= 16'd1234;
        waitSamples(2);
        chk16(voltageSetValue_r, 16'd26214);
        chk16(voltageActualOutput_r, 16'd26214);
        chk16(currentActualOutput_r, 16'd1234);
        regWrite(4'h0, 16'h0004);
        voltageSetpointInput <= 16'd6000;
        currentSetpointInput <= 16'd14000;
        voltageActual <= 16'd20000;
        waitSamples(2);
        chk16(referenceOutput_r, 16'd13107);
        chk16(voltageSetValue_r, 16'd12000);
        chk16(currentSetValue_r, 16'd26214);
        chk16(voltageActualOutput_r, 16'd10000);
        regWrite(4'h0, 16'h0005);
        $display("Test range done");
    endtask
    task testAlarm(input logic [4:0] route, input logic [4:0] ev, input logic a1, input logic a2);
        regWrite(4'h4, {11'h0, route});
        @(posedge clk_sys);
        alarmEvent <= ev;
        @(posedge clk_sys);
        alarmEvent <= 5'h00;
        #1 chkBit(dcOutputOn_r, 1'b0);
        waitSamples(1);
        chkBit(alarm1Output_r, a1);
        chkBit(alarm2Output_r, a2);
        regRead(4'h8, rd);
        chk16(rd, {3'h0, ev, 8'h01});
        ackPulse(16'd15, 4);
        chkBit(alarm1Output_r | alarm2Output_r, 1'b1);
        ackPulse(16'd45, 7);
        chkBit(alarm1Output_r | alarm2Output_r, 1'b0);
        chkBit(dcOutputOn_r, 1'b1);
        $display("Test alarm done");
    endtask
    task testLocalDigital;
        regWrite(4'h0, 16'h0001);
        waitActive(1'b0);
        regWrite(4'h0, 16'h0005);
        waitActive(1'b1);
        wantRemote <= 1'b0;
        waitActive(1'b0);
        pulse(0);
        waitSamples(1);
        chk16({13'h0, controlOwner_r}, 16'h0003);
        regRead(4'h8, rd);
        chk16(rd, 16'h0006);
        regRead(4'hc, rd);
        chk16(rd, 16'h0003);
        wantRemote <= 1'b1;
        ackPulse(16'd40, 3);
        chkBit(dcOutputOn_r, 1'b0);
        chkBit(analogActive_r, 1'b0);
        pulse(1);
        waitSamples(3);
        chkBit(analogActive_r, 1'b0);
        chkBit(dcOutputOn_r, 1'b1);
        wantRemote <= 1'b0;
        waitSamples(2);
        wantRemote <= 1'b1;
        waitActive(1'b1);
        regWrite(4'h0, 16'h0007);
        waitSamples(2);
        chkBit(dcOutputOn_r, 1'b0);
        regWrite(4'h0, 16'h0005);
        waitSamples(2);
        chkBit(dcOutputOn_r, 1'b1);
        $display("Test local and digital done");
    endtask
    task give_verdict;
        $display("Comparisons %0d mismatches %0d", testsRun, errors);
        if (errors == 0 && testsRun > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        waitSamples(2);
        testRegisters;
        testAnalog;
        testRange;
        testAlarm(5'h1c, 5'h05, 1'b1, 1'b1);
        testAlarm(5'h0a, 5'h15, 1'b1, 1'b0);
        testAlarm(5'h0a, 5'h0a, 1'b0, 1'b1);
        testLocalDigital;
        give_verdict;
    end
endmodule
